// *** core/sfr_pin_sync.sv ***
// Purpose: Two-stage synchronisers and edge detection for the link pins.
// Assumes: The system clock is several times faster than the link clock.
// Notes:   All pins share one delay, so data stays aligned with clock edges.
`timescale 1ns/1ps
module sfr_pin_sync (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic            cs_n_s_o,
  output logic [3:0]      io_s_o,
  output logic            sclk_rise_o,
  output logic            sclk_fall_o
);

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic       sclk_last_q;

  // The first stage is read only by the second; idle level of chip select is high.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q      <= 6'h20;
      sync_q      <= 6'h20;
      sclk_last_q <= 1'b0;
    end else begin
      meta_q      <= {cs_n_i, sclk_i, io_i};
      sync_q      <= meta_q;
      sclk_last_q <= sync_q[4];
    end
  end

  assign cs_n_s_o    = sync_q[5];
  assign io_s_o      = sync_q[3:0];
  assign sclk_rise_o = sync_q[4] & ~sclk_last_q;
  assign sclk_fall_o = ~sync_q[4] & sclk_last_q;

endmodule : sfr_pin_sync

// *** core/sfr_pkg.sv ***
// Purpose: Shared constants and types of the serial flash read engine.
// Assumes: Link pins are sampled by a much faster system clock.
// Notes:   Opcode values and the array size are plain defaults.
package sfr_pkg;

  localparam int          ADDR_BITS        = 32;
  localparam int          BYTE_BITS        = 8;
  // Highest array byte address; the counter wraps to zero after it.
  localparam logic [31:0] ARRAY_LAST_ADDR  = 32'h00ff_ffff;
  localparam logic [31:0] ADDR_ZERO        = 32'h0000_0000;

  // Opcodes of the seven array-read commands.
  localparam logic [7:0]  OP_BASIC_READ    = 8'h11;
  localparam logic [7:0]  OP_SINGLE_FETCH  = 8'h12;
  localparam logic [7:0]  OP_DUAL_OUTPUT   = 8'h14;
  localparam logic [7:0]  OP_DUAL_IO       = 8'h18;
  localparam logic [7:0]  OP_QUAD_OUTPUT   = 8'h1c;
  localparam logic [7:0]  OP_QUAD_IO       = 8'heb;
  localparam logic [7:0]  OP_QUAD_IO_DTR   = 8'hed;

  // Dummy clocks: fixed default and the four dummy_count_sel settings.
  localparam logic [3:0]  DUMMY_DEFAULT    = 4'ha;
  localparam logic [3:0]  DUMMY_SEL_0      = 4'ha;
  localparam logic [3:0]  DUMMY_SEL_1      = 4'h6;
  localparam logic [3:0]  DUMMY_SEL_2      = 4'h8;
  localparam logic [3:0]  DUMMY_SEL_3      = 4'ha;
  localparam logic [3:0]  DUMMY_NONE       = 4'h0;

  // Register map (byte addresses on the AXI4-Lite port).
  localparam logic [7:0]  REG_CFG_OFS      = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS     = 8'h04;
  localparam logic [7:0]  REG_ADDR_OFS     = 8'h08;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam int          CFG_FWIRE_BIT    = 0;
  localparam int          CFG_DCS_LO_BIT   = 6;
  localparam int          CFG_DCS_HI_BIT   = 7;
  localparam int          STAT_BUSY_BIT    = 0;
  localparam int          STAT_ACTIVE_BIT  = 1;
  localparam int          STAT_DATA_BIT    = 2;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CMD   = 6'h02,
    ST_ADDR  = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA  = 6'h10,
    ST_SKIP  = 6'h20
  } sfr_state_t;

endpackage : sfr_pkg

// *** core/sfr_read_engine.sv ***
// Purpose: Array-read command engine of a serial NOR flash, device side.
// Assumes: Array data arrives on mem_rdata_i within four clocks of mem_addr_o.
// Notes:   Configuration and status are reached over an AXI4-Lite slave.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - Sample address rising, drive data falling
// - Any start address is accepted
// - Address counter advances after each byte
// - Counter wraps to zero past array top
// - Basic read: address then data, no dummy
// - Chip select high ends read, stops driving
// - Single fetch waits ten dummy clocks
// - Busy write cycle rejects all but basic
// - Dual output: lane0 address, two-bit data
// - Dual io: address, dummy, data two lanes
// - Quad output: serial address, four-lane data
// - Quad io: address and data four lanes
// - Quad io accepted in four-wire mode
// - Quad dummy count from config bits 6,7
// - Double edge: four bits each edge
// - Double edge phases carry eight bits per clock
// - Double edge opcode: eight or two clocks
// - Busy flag follows internal write cycle
module sfr_read_engine (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Link pins.
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_o,
  // Array read port and write-cycle state.
  output logic [31:0]      mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        wr_cycle_run_i,
  output logic             write_busy_flag_o,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [3:0] io,
                                           input logic [2:0] lanes);
    logic [31:0] r;
    r = {v[27:0], io};
    if (lanes == 3'd1) begin
      r = {v[30:0], io[0]};
    end else if (lanes == 3'd2) begin
      r = {v[29:0], io[1:0]};
    end
    return r;
  endfunction : shift_in

  function automatic logic [31:0] next_addr(input logic [31:0] a);
    return (a >= sfr_pkg::ARRAY_LAST_ADDR) ? sfr_pkg::ADDR_ZERO : a + 32'h0000_0001;
  endfunction : next_addr

  logic             cs_n_s;
  logic [3:0]       io_s;
  logic             sclk_rise;
  logic             sclk_fall;
  sfr_pkg::sfr_state_t state_q;
  logic [7:0]       cmd_q;
  logic [31:0]      addr_q;
  logic [5:0]       cnt_q;
  logic [2:0]       lanes_in_q;
  logic [2:0]       lanes_out_q;
  logic             dtr_q;
  logic [3:0]       dummy_q;
  logic [7:0]       sh_q;
  logic [3:0]       obit_q;
  logic [3:0]       io_out_q;
  logic [3:0]       io_oe_q;
  logic             busy_q;
  logic [7:0]       cfg_q;
  logic [7:0]       cmd_d;
  logic [2:0]       cmd_lanes;
  logic             dec_ok;
  logic [2:0]       dec_ain;
  logic [2:0]       dec_aout;
  logic             dec_dtr;
  logic [3:0]       dec_dummy;
  logic [3:0]       quad_dummy;
  logic             in_edge;
  logic             out_edge;
  logic [7:0]       src_byte;
  logic [3:0]       obits_left;

  sfr_pin_sync u_sync (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .io_i        (io_i),
    .cs_n_s_o    (cs_n_s),
    .io_s_o      (io_s),
    .sclk_rise_o (sclk_rise),
    .sclk_fall_o (sclk_fall)
  );

  // Four-wire mode takes the opcode on all lanes in two clocks; otherwise lane 0 only.
  assign cmd_lanes  = cfg_q[sfr_pkg::CFG_FWIRE_BIT] ? 3'd4 : 3'd1;
  assign cmd_d      = (cmd_lanes == 3'd4) ? {cmd_q[3:0], io_s} : {cmd_q[6:0], io_s[0]};
  assign in_edge    = sclk_rise | (dtr_q & sclk_fall);
  assign out_edge   = sclk_fall | (dtr_q & sclk_rise);

  always_comb begin
    unique case ({cfg_q[sfr_pkg::CFG_DCS_HI_BIT], cfg_q[sfr_pkg::CFG_DCS_LO_BIT]})
      2'b00:   quad_dummy = sfr_pkg::DUMMY_SEL_0;
      2'b01:   quad_dummy = sfr_pkg::DUMMY_SEL_1;
      2'b10:   quad_dummy = sfr_pkg::DUMMY_SEL_2;
      2'b11:   quad_dummy = sfr_pkg::DUMMY_SEL_3;
    endcase
  end

  always_comb begin
    dec_ok    = 1'b1;
    dec_ain   = 3'd1;
    dec_aout  = 3'd1;
    dec_dtr   = 1'b0;
    dec_dummy = sfr_pkg::DUMMY_DEFAULT;
    unique case (cmd_d)
      sfr_pkg::OP_BASIC_READ:   dec_dummy = sfr_pkg::DUMMY_NONE;
      sfr_pkg::OP_SINGLE_FETCH: dec_dummy = sfr_pkg::DUMMY_DEFAULT;
      sfr_pkg::OP_DUAL_OUTPUT:  dec_aout = 3'd2;
      sfr_pkg::OP_DUAL_IO: begin
        dec_ain  = 3'd2;
        dec_aout = 3'd2;
      end
      sfr_pkg::OP_QUAD_OUTPUT: begin
        dec_aout  = 3'd4;
        dec_dummy = quad_dummy;
      end
      sfr_pkg::OP_QUAD_IO: begin
        dec_ain   = 3'd4;
        dec_aout  = 3'd4;
        dec_dummy = quad_dummy;
      end
      sfr_pkg::OP_QUAD_IO_DTR: begin
        dec_ain   = 3'd4;
        dec_aout  = 3'd4;
        dec_dtr   = 1'b1;
        dec_dummy = quad_dummy;
      end
      default: dec_ok = 1'b0;
    endcase
    // Only the four-lane-address reads, quad io and quad io dtr, exist in four-wire mode.
    if (cfg_q[sfr_pkg::CFG_FWIRE_BIT] && !dec_ain[2]) begin
      dec_ok = 1'b0;
    end
    if (busy_q && cmd_d != sfr_pkg::OP_BASIC_READ) begin
      dec_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= wr_cycle_run_i;
    end
  end

  // Link sequencer: command, address, dummy, data.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q     <= sfr_pkg::ST_IDLE;
      cmd_q       <= 8'h00;
      cnt_q       <= 6'h00;
      lanes_in_q  <= 3'd1;
      lanes_out_q <= 3'd1;
      dtr_q       <= 1'b0;
      dummy_q     <= 4'h0;
    end else if (cs_n_s) begin
      state_q <= sfr_pkg::ST_IDLE;
      dtr_q   <= 1'b0;
    end else begin
      unique case (state_q)
        sfr_pkg::ST_IDLE: begin
          state_q <= sfr_pkg::ST_CMD;
          cmd_q   <= 8'h00;
          cnt_q   <= 6'h00;
        end
        sfr_pkg::ST_CMD: begin
          if (sclk_rise) begin
            cmd_q <= cmd_d;
            cnt_q <= cnt_q + {3'b000, cmd_lanes};
            if (cnt_q + {3'b000, cmd_lanes} == 6'(sfr_pkg::BYTE_BITS)) begin
              cnt_q       <= 6'h00;
              lanes_in_q  <= dec_ain;
              lanes_out_q <= dec_aout;
              dtr_q       <= dec_dtr;
              dummy_q     <= dec_dummy;
              // A refused command holds off in ST_SKIP until chip select rises; lanes, dtr and dummy are still loaded.
              state_q     <= dec_ok ? sfr_pkg::ST_ADDR : sfr_pkg::ST_SKIP;
            end
          end
        end
        sfr_pkg::ST_ADDR: begin
          if (in_edge) begin
            cnt_q <= cnt_q + {3'b000, lanes_in_q};
            if (cnt_q + {3'b000, lanes_in_q} == 6'(sfr_pkg::ADDR_BITS)) begin
              cnt_q   <= 6'h00;
              state_q <= (dummy_q == sfr_pkg::DUMMY_NONE) ? sfr_pkg::ST_DATA
                                                         : sfr_pkg::ST_DUMMY;
            end
          end
        end
        sfr_pkg::ST_DUMMY: begin
          // Dummy clocks are counted on rising edges only, also in double-edge mode.
          if (sclk_rise) begin
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q[3:0] + 4'd1 == dummy_q) begin
              state_q <= sfr_pkg::ST_DATA;
            end
          end
        end
        sfr_pkg::ST_DATA: state_q <= sfr_pkg::ST_DATA;
        sfr_pkg::ST_SKIP: state_q <= sfr_pkg::ST_SKIP;
      endcase
    end
  end

  // Address counter doubles as the array read address.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= sfr_pkg::ADDR_ZERO;
    end else if (!cs_n_s && state_q == sfr_pkg::ST_ADDR && in_edge) begin
      addr_q <= shift_in(addr_q, io_s, lanes_in_q);
    end else if (!cs_n_s && state_q == sfr_pkg::ST_DATA && out_edge && obit_q == 4'h0) begin
      addr_q <= next_addr(addr_q);
    end
  end

  assign mem_addr_o = addr_q;
  assign src_byte   = (obit_q == 4'h0) ? mem_rdata_i : sh_q;
  assign obits_left = ((obit_q == 4'h0) ? 4'd8 : obit_q) - {1'b0, lanes_out_q};

  // Output shifter: each byte leaves msb first, lane1 holds the higher bit of a pair.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_q     <= 8'h00;
      obit_q   <= 4'h0;
      io_out_q <= 4'h0;
      io_oe_q  <= 4'h0;
    end else if (cs_n_s || state_q != sfr_pkg::ST_DATA) begin
      obit_q  <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (out_edge) begin
      obit_q <= obits_left;
      unique case (lanes_out_q)
        3'd1: begin
          io_out_q <= {2'b00, src_byte[7], 1'b0};
          io_oe_q  <= 4'b0010;
          sh_q     <= {src_byte[6:0], 1'b0};
        end
        3'd2: begin
          io_out_q <= {2'b00, src_byte[7:6]};
          io_oe_q  <= 4'b0011;
          sh_q     <= {src_byte[5:0], 2'b00};
        end
        default: begin
          io_out_q <= src_byte[7:4];
          io_oe_q  <= 4'b1111;
          sh_q     <= {src_byte[3:0], 4'h0};
        end
      endcase
    end
  end

  assign io_o              = io_out_q;
  assign io_oe_o           = io_oe_q;
  assign write_busy_flag_o = busy_q;

  // AXI4-Lite slave; write address and data are taken in either order.
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sfr_pkg::RESP_OKAY;
      cfg_q     <= sfr_pkg::CFG_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= sfr_pkg::RESP_SLVERR;
        if (awaddr_q == sfr_pkg::REG_CFG_OFS) begin
          bresp_q <= sfr_pkg::RESP_OKAY;
          if (wstrb_q[0]) begin
            cfg_q <= wdata_q[7:0];
          end
        end else if (awaddr_q == sfr_pkg::REG_STAT_OFS || awaddr_q == sfr_pkg::REG_ADDR_OFS) begin
          bresp_q <= sfr_pkg::RESP_OKAY;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_q <= 1'b0;
      rresp_q  <= sfr_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= sfr_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        sfr_pkg::REG_CFG_OFS:  rdata_q <= {24'h00_0000, cfg_q};
        sfr_pkg::REG_STAT_OFS: begin
          rdata_q[sfr_pkg::STAT_BUSY_BIT]   <= busy_q;
          rdata_q[sfr_pkg::STAT_ACTIVE_BIT] <= (state_q != sfr_pkg::ST_IDLE);
          rdata_q[sfr_pkg::STAT_DATA_BIT]   <= (state_q == sfr_pkg::ST_DATA);
        end
        sfr_pkg::REG_ADDR_OFS: rdata_q <= addr_q;
        default:               rresp_q <= sfr_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : sfr_read_engine

// *** sim/sfr_host_model.sv ***
// Purpose: Host end of the serial link: frames reads and captures data.
// Assumes: Clock idles low, half period 32 ns.
// Notes:   Released lanes toggle so stale values never pass for data.
`timescale 1ns/1ps
module sfr_host_model (
  input  logic       clk_i,
  input  logic [3:0] pad_i,
  input  logic [3:0] oe_i,
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] io_o
);
  logic [7:0] got [0:7];
  logic [3:0] oe_seen;
  logic [3:0] sm;
  initial begin
    {sclk_o, cs_n_o, io_o} = 6'h10;
  end
  // Lanes change mid-half so they are settled at every clock edge.
  task put(input logic lvl, input logic [3:0] v);
    io_o <= v;
    #16;
    sm = pad_i;
    oe_seen = oe_i;
    sclk_o <= lvl;
    #16;
  endtask : put
  task tick(input logic [3:0] v);
    put(1'b0, v);
    put(1'b1, v);
  endtask : tick
  task frame(input logic [7:0] op, input bit fw, input int al, input int dl,
             input int nd, input logic [31:0] a, input int nb, input bit cut);
    int i, k, st;
    logic [7:0] sh;
    @(posedge clk_i);
    #1.3;
    cs_n_o <= 1'b0;
    #40;
    for (i = 0; i < (fw ? 2 : 8); i++)
      tick(fw ? op[7-4*i -: 4] : {3'($urandom), op[7-i]});
    // Double-edge address starts on the fall that follows the last opcode rise.
    for (i = 0; i < (al == 8 ? 8 : 32 / al); i++) begin
      if (al == 8) put(1'(i % 2 == 1), a[31:28]);
      else tick(4'(a >> (32 - al)));
      a = a << (al == 8 ? 4 : al);
    end
    for (i = 0; i < nd; i++)
      tick(4'h0);
    st = (al == 8) ? 2 * nb + 1 : 16 * nb / dl;
    if (cut) st = st / 2;
    k = 0;
    sh = 8'h00;
    for (i = 0; i < st; i++) begin
      put((al == 8 && i == st - 1) ? sclk_o : 1'(i % 2), ~io_o);
      if (al == 8 ? i > 0 : i % 2 == 1) begin
        sh = (sh << dl) | 8'(dl == 1 ? {3'h0, sm[1]} : sm & 4'((1 << dl) - 1));
        k += dl;
        if (k % 8 == 0) got[k/8-1] = sh;
      end
    end
    cs_n_o <= 1'b1;
    #16;
    sclk_o <= 1'b0;
    #80;
  endtask : frame
endmodule : sfr_host_model

// *** sim/sfr_read_engine_chk.sv ***
// Purpose: Port-level temporal checks of the read engine.
// Assumes: Link pins reach the engine through a short synchroniser.
// Notes:   Bound to every instance of the engine.
`timescale 1ns/1ps
module sfr_read_engine_chk (
  input logic        clk_i,
  input logic        arst_n_i,
  input logic        sclk_i,
  input logic        cs_n_i,
  input logic        wr_cycle_run_i,
  input logic [3:0]  io_o,
  input logic [3:0]  io_oe_o,
  input logic [31:0] mem_addr_o,
  input logic        write_busy_flag_o,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_desel; cs_n_i [*5] |-> io_oe_o == 4'h0; endproperty
  a_desel: assert property (p_desel)
    else $error("lanes driven while deselected");
  property p_quiet; $fell(cs_n_i) |-> (io_oe_o == 4'h0) [*8]; endproperty
  a_quiet: assert property (p_quiet)
    else $error("lanes driven during command phase");
  property p_oe; io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
  a_oe: assert property (p_oe)
    else $error("illegal lane enable pattern");
  property p_set; $rose(wr_cycle_run_i) |=> write_busy_flag_o; endproperty
  a_set: assert property (p_set)
    else $error("busy flag did not rise");
  property p_clr; $fell(wr_cycle_run_i) |=> !write_busy_flag_o; endproperty
  a_clr: assert property (p_clr)
    else $error("busy flag did not clear");
  property p_fall; $changed(io_o) && io_oe_o == 4'h2 |-> !$past(sclk_i, 3); endproperty
  a_fall: assert property (p_fall)
    else $error("single lane data changed after a rising clock");
  property p_step;
    $changed(mem_addr_o) && io_oe_o != 4'h0 && $past(io_oe_o) != 4'h0 &&
      $past(mem_addr_o) != sfr_pkg::ARRAY_LAST_ADDR |-> mem_addr_o == $past(mem_addr_o) + 32'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("address counter did not step by one");
  property p_wrap;
    $changed(mem_addr_o) && io_oe_o != 4'h0 &&
      $past(mem_addr_o) == sfr_pkg::ARRAY_LAST_ADDR |-> mem_addr_o == 32'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("address counter did not wrap to zero");
  property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b: assert property (p_b)
    else $error("write response dropped early");
  property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r: assert property (p_r)
    else $error("read data dropped early");
endmodule : sfr_read_engine_chk

bind sfr_read_engine sfr_read_engine_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .wr_cycle_run_i(wr_cycle_run_i), .io_o(io_o),
  .io_oe_o(io_oe_o), .mem_addr_o(mem_addr_o), .write_busy_flag_o(write_busy_flag_o),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** sim/testbench.sv ***
// Purpose: Self-checking bench of the serial flash read engine.
// Assumes: The array byte at address A is a fixed hash of A.
// Notes:   Quad reads take their dummy count from the config register.
`timescale 1ns/1ps
module testbench;
  logic        clk_i, arst_n_i, wr_run, sclk, cs_n, busy, bready, rready;
  logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [7:0]  mem_q, awaddr, araddr, cfg;
  logic [31:0] wdata, rdata, mem_addr, q;
  logic [3:0]  io_o, io_oe, hio, pad;
  logic [1:0]  bresp, rresp, r;
  int          fail_count, checked, i, m;
  logic [7:0]  ops [7] = '{sfr_pkg::OP_BASIC_READ, sfr_pkg::OP_SINGLE_FETCH,
    sfr_pkg::OP_DUAL_OUTPUT, sfr_pkg::OP_DUAL_IO, sfr_pkg::OP_QUAD_OUTPUT,
    sfr_pkg::OP_QUAD_IO, sfr_pkg::OP_QUAD_IO_DTR};
  int          al [7] = '{1, 1, 1, 2, 1, 4, 8};
  int          dl [7] = '{1, 1, 2, 2, 4, 4, 4};

  assign pad = (io_oe & io_o) | (~io_oe & hio);
  sfr_read_engine u_sfr_read_engine (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(pad), .io_o(io_o), .io_oe_o(io_oe), .mem_addr_o(mem_addr),
    .mem_rdata_i(mem_q), .wr_cycle_run_i(wr_run), .write_busy_flag_o(busy),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sfr_host_model u_host (.clk_i(clk_i), .pad_i(pad), .oe_i(io_oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .io_o(hio));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) mem_q <= mf(mem_addr);

  function automatic logic [7:0] mf(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
  endfunction : mf
  function automatic logic [31:0] nx(input logic [31:0] a);
    return (a == sfr_pkg::ARRAY_LAST_ADDR) ? 32'h0 : a + 32'h1;
  endfunction : nx
  function automatic int dum(input int md, input logic [7:0] c);
    logic [3:0] s [4];
    s = '{sfr_pkg::DUMMY_SEL_0, sfr_pkg::DUMMY_SEL_1, sfr_pkg::DUMMY_SEL_2,
          sfr_pkg::DUMMY_SEL_3};
    if (md == 0) return 0;
    return (md < 4) ? 10 : int'(s[c[7:6]]);
  endfunction : dum
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task guard(inout int n);
    n++;
    if (n > 400) begin
      fail_count++;
      wrap_up();
    end
  endtask : guard
  task ax(input bit wr, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] rd, output logic [1:0] rs);
    bit p1, p2, t1, t2;
    int n;
    p1 = 1'b1;
    p2 = wr;
    n = 0;
    @(posedge clk_i);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, wr, wr};
    {araddr, arvalid} <= {a, !wr};
    while (p1 || p2) begin
      @(negedge clk_i);
      t1 = wr ? awready : arready;
      t2 = wready;
      @(posedge clk_i);
      guard(n);
      if (p1 && t1) begin
        p1 = 1'b0;
        {awvalid, arvalid} <= 2'b00;
      end
      if (p2 && t2) begin
        p2 = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // A late ready lets the response be seen standing.
    repeat ($urandom % 3) @(posedge clk_i);
    {bready, rready} <= {wr, !wr};
    t1 = 1'b0;
    while (!t1) begin
      @(negedge clk_i);
      t1 = wr ? bvalid : rvalid;
      rd = rdata;
      rs = wr ? bresp : rresp;
      @(posedge clk_i);
      guard(n);
    end
    {bready, rready} <= 2'b00;
  endtask : ax
  task wcfg(input logic [7:0] c);
    cfg = c;
    ax(1'b1, sfr_pkg::REG_CFG_OFS, 32'(c), q, r);
  endtask : wcfg
  task run(input int md, input logic [31:0] a, input int nb, input bit fw, input bit ok);
    logic [31:0] e;
    logic [3:0] x;
    int j;
    e = a;
    x = dl[md] == 1 ? 4'h2 : dl[md] == 2 ? 4'h3 : 4'hf;
    u_host.frame(ops[md], fw, al[md], dl[md], dum(md, cfg), a, nb, 1'b0);
    chk("lane_oe", 32'(u_host.oe_seen), ok ? 32'(x) : 32'h0);
    for (j = 0; j < nb && ok; j++) begin
      chk("data", 32'(u_host.got[j]), 32'(mf(e)));
      e = nx(e);
    end
    if (ok) begin
      ax(1'b0, sfr_pkg::REG_ADDR_OFS, 32'h0, q, r);
      chk("addr_reg", q, e);
    end
  endtask : run

  initial begin
    void'($urandom(32'h02c0));
    {awvalid, wvalid, arvalid, bready, rready, wr_run, arst_n_i} = 7'h00;
    {awaddr, araddr, wdata, mem_q, cfg, fail_count, checked} = '0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    ax(1'b0, sfr_pkg::REG_CFG_OFS, 32'h0, q, r);
    chk("cfg_reset", q, 32'(sfr_pkg::CFG_RESET));
    wcfg(8'hc1);
    ax(1'b0, sfr_pkg::REG_CFG_OFS, 32'h0, q, r);
    chk("cfg_back", q, 32'hc1);
    ax(1'b1, sfr_pkg::REG_STAT_OFS, 32'hffff_ffff, q, r);
    chk("ro_resp", 32'(r), 32'(sfr_pkg::RESP_OKAY));
    ax(1'b0, sfr_pkg::REG_STAT_OFS, 32'h0, q, r);
    chk("stat_idle", q, 32'h0);
    ax(1'b1, 8'h10, 32'h1, q, r);
    chk("bad_wr", 32'(r), 32'(sfr_pkg::RESP_SLVERR));
    ax(1'b0, 8'h10, 32'h0, q, r);
    chk("bad_rd", {q[29:0], r}, {30'h0, sfr_pkg::RESP_SLVERR});
    for (i = 0; i < 14; i++) begin
      wcfg({2'($urandom), 6'h00});
      run(i % 7, $urandom & sfr_pkg::ARRAY_LAST_ADDR, 2 + i / 7, 1'b0, 1'b1);
    end
    wcfg(8'h40);
    run(0, sfr_pkg::ARRAY_LAST_ADDR - 32'h1, 3, 1'b0, 1'b1);
    run(6, sfr_pkg::ARRAY_LAST_ADDR, 2, 1'b0, 1'b1);
    wr_run <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("busy_on", 32'(busy), 32'h1);
    for (m = 1; m < 7; m++)
      run(m, $urandom & sfr_pkg::ARRAY_LAST_ADDR, 1, 1'b0, 1'b0);
    run(0, $urandom & sfr_pkg::ARRAY_LAST_ADDR, 2, 1'b0, 1'b1);
    wr_run <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("busy_off", 32'(busy), 32'h0);
    wcfg(8'h81);
    run(5, $urandom & sfr_pkg::ARRAY_LAST_ADDR, 2, 1'b1, 1'b1);
    run(6, $urandom & sfr_pkg::ARRAY_LAST_ADDR, 2, 1'b1, 1'b1);
    run(1, $urandom & sfr_pkg::ARRAY_LAST_ADDR, 1, 1'b1, 1'b0);
    wcfg(8'h00);
    u_host.frame(ops[0], 1'b0, 1, 1, 0, 32'h100, 2, 1'b1);
    chk("abort_oe", 32'(io_oe), 32'h0);
    run(0, 32'h100, 1, 1'b0, 1'b1);
    wrap_up();
  end
endmodule : testbench
